// file: pos_seq_pkg.sv
// constants, carriers and states of the stroke position sequencer
package pos_seq_pkg;

   // ****************************************************************
   // widths and timing
   // ****************************************************************
   localparam int POS_W       = 16;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 32;
   localparam int GAIN_SHIFT  = 4;
   localparam int CLK_PER_PS  = 5000;
   localparam int SAMPLE_MS   = 1;
   localparam int SAMPLE_CYC  = SAMPLE_MS * 1000000000 / CLK_PER_PS;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_WIN    = 8'h04;
   localparam logic [7:0] REG_JOG    = 8'h08;
   localparam logic [7:0] REG_DECEL  = 8'h0C;
   localparam logic [7:0] REG_VLIM   = 8'h10;
   localparam logic [7:0] REG_EMERG  = 8'h14;
   localparam logic [7:0] REG_GAIN   = 8'h18;
   localparam logic [7:0] REG_TRIG   = 8'h1C;
   localparam logic [7:0] REG_FILT   = 8'h20;
   localparam logic [7:0] REG_CBLVL  = 8'h24;
   localparam logic [7:0] REG_STATUS = 8'h28;
   localparam logic [7:0] REG_ISTAT  = 8'h2C;
   localparam logic [7:0] REG_IMASK  = 8'h30;
   localparam logic [7:0] REG_MEAS   = 8'h34;
   localparam logic [7:0] REG_TARGET = 8'h38;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int CTRL_W          = 6;
   localparam int CTRL_CUR_BIT    = 0;
   localparam int CTRL_POL_BIT    = 1;
   localparam int CTRL_NC_BIT     = 2;
   localparam int CTRL_EXTV_BIT   = 3;
   localparam int CTRL_EMDIS_BIT  = 4;
   localparam int CTRL_LOOP_BIT   = 5;
   localparam int IRQ_W           = 3;
   localparam int IRQ_FAULT_BIT   = 0;
   localparam int IRQ_INPOS_BIT   = 1;
   localparam int IRQ_ENLOSS_BIT  = 2;
   localparam int FILT_W          = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
   localparam logic [15:0]       WIN_RST   = 16'h0040;
   localparam logic [15:0]       JOG_RST   = 16'h1000;
   localparam logic [15:0]       DECEL_RST = 16'h0100;
   localparam logic [15:0]       VLIM_RST  = 16'h7FFF;
   localparam logic [15:0]       EMERG_RST = 16'h0000;
   localparam logic [7:0]        GAIN_RST  = 8'h10;
   localparam logic [15:0]       TRIG_RST  = 16'h0000;
   localparam logic [FILT_W-1:0] FILT_RST  = 4'h2;
   localparam logic [15:0]       CBLVL_RST = 16'h0CCC;

   // ****************************************************************
   // carriers and states
   // ****************************************************************
   typedef struct packed {
      logic enable;
      logic start;
      logic jog_up;
      logic jog_down;
   } switch_type;

   typedef struct packed {
      logic loop_sensor;
      logic emerg_disable;
      logic ext_speed;
      logic nc_mode;
      logic polarity_inv;
      logic current_mode;
   } ctrl_type;

   typedef enum logic [1:0] {ST_OFF, ST_HOLD, ST_JOG, ST_RUN} state_type;

endpackage : pos_seq_pkg

// file: stroke_position_sequencer.sv
// sequencer, control path and register file of the stroke positioner
// How it works
// R1: enable loads target with measured position, closed loop, valve active
// R2: ready output shows enable together with health monitoring
// R3: ready only while enable active and no sensor fault
// R4: in-position drops when target-measured error exceeds window
// R5: in-position held low while start is off
// R6: jog input with start off drives open loop at jog velocity
// R7: jog release loads target with measured position, holds closed loop
// R8: start on takes analogue position command as target
// R9: start dropped while moving sets target to measured plus decel distance
// R10: one control bit selects valve output form and polarity; code uses bit 0 for the form and bit 1 for the polarity
// R11: two control modes, stroke dependent decel or profile following
// R12: velocity limited by internal limit or analogue speed command
// R13: cable break on feedback or command input is a fault
// R14: first order lag filter in the control path
// R15: deadband compensated by two-slope gain, no step offset
// R16: on fault or enable loss valve forced to emergency value
// R17: sequencer and control path evaluated once per one millisecond sample; interrupt and read logic run every clock
`timescale 1ns/1ps
module stroke_position_sequencer
   import pos_seq_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              enable_in,
   input  wire logic              start_in,
   input  wire logic              jog_up_in,
   input  wire logic              jog_down_in,
   input  wire logic [POS_W-1:0]  position_cmd,
   input  wire logic [POS_W-1:0]  speed_cmd,
   input  wire logic [POS_W-1:0]  feedback_pos,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rd_data,
   output logic [POS_W-1:0]       valve_out,
   output logic                   valve_current_mode,
   output logic                   ready_out,
   output logic                   inpos_out,
   output logic                   irq
);

   localparam int TW = $clog2(SAMPLE_CYCLES + 1);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [16:0] abs17(input logic signed [17:0] v);
      logic signed [17:0] n;
      n = -v;
      abs17 = v[17] ? n[16:0] : v[16:0];
   endfunction : abs17

   // clamp to -32767..32767, the symmetric signed 16-bit range of the valve word
   function automatic logic [15:0] sat16(input logic signed [27:0] v);
      if (v > 28'sd32767)
         sat16 = 16'h7FFF;
      else if (v < -28'sd32767)
         sat16 = 16'h8001;
      else
         sat16 = v[15:0];
   endfunction : sat16

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [3:0] pins;
   logic [3:0] s1_r, s2_r, s3_r, sw_r;
   logic [3:0] agree;
   switch_type sw;
   assign pins  = {enable_in, start_in, jog_up_in, jog_down_in};
   assign agree = s2_r ~^ s3_r;
   assign sw    = switch_type'(sw_r);

   // a level counts only once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         s3_r <= 4'h0;
         sw_r <= 4'h0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         sw_r <= (agree & s3_r) | (~agree & sw_r);
      end
   end

   // ****************************************************************
   // sample tick
   // ****************************************************************
   logic [TW-1:0] tick_cnt_r;
   logic          tick;
   assign tick = (tick_cnt_r == TW'(SAMPLE_CYCLES - 1));

   always_ff @(posedge sys_clk) begin
      if (!resetn)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1); // R17
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   ctrl_type          ctrl_r;
   logic [15:0]       win_r, jog_r, decel_r, vlim_r, emerg_r, trig_r, cblvl_r;
   logic [7:0]        gain_r;
   logic [FILT_W-1:0] filt_sh_r;
   logic [IRQ_W-1:0]  istat_r, imask_r, istat_nxt, events;
   logic              wr_istat;
   assign wr_istat  = wr_en && (addr == REG_ISTAT);
   // set wins over the write-one clear
   assign istat_nxt = (istat_r & ~(wr_istat ? wr_data[IRQ_W-1:0] : '0)) | events;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_r    <= ctrl_type'(CTRL_RST);
         win_r     <= WIN_RST;
         jog_r     <= JOG_RST;
         decel_r   <= DECEL_RST;
         vlim_r    <= VLIM_RST;
         emerg_r   <= EMERG_RST;
         gain_r    <= GAIN_RST;
         trig_r    <= TRIG_RST;
         filt_sh_r <= FILT_RST;
         cblvl_r   <= CBLVL_RST;
         imask_r   <= '0;
      end else if (wr_en) begin
         case (addr)
            REG_CTRL:  ctrl_r    <= ctrl_type'(wr_data[CTRL_W-1:0]);
            REG_WIN:   win_r     <= wr_data[15:0];
            REG_JOG:   jog_r     <= wr_data[15:0];
            REG_DECEL: decel_r   <= wr_data[15:0];
            REG_VLIM:  vlim_r    <= wr_data[15:0];
            REG_EMERG: emerg_r   <= wr_data[15:0];
            REG_GAIN:  gain_r    <= wr_data[7:0];
            REG_TRIG:  trig_r    <= wr_data[15:0];
            REG_FILT:  filt_sh_r <= wr_data[FILT_W-1:0];
            REG_CBLVL: cblvl_r   <= wr_data[15:0];
            REG_IMASK: imask_r   <= wr_data[IRQ_W-1:0];
            default: ; // unmapped and read-only offsets ignore writes
         endcase
      end
   end

   // ****************************************************************
   // health and loop errors
   // ****************************************************************
   logic              fault, fault_q_r, moving;
   logic [15:0]       tgt_r, prof_r, tgt_nxt, prof_nxt, decel_tgt;
   logic signed [17:0] err_t, err_p, err_l;
   logic [16:0]       abs_t, abs_rp, vlim;
   logic signed [17:0] step, rp;
   logic [16:0]       dec_sum;
   logic signed [17:0] dec_dif;
   state_type         state_r, state_nxt;

   // broken loop reads below the live-zero level
   assign fault = ctrl_r.loop_sensor
                  && (feedback_pos < cblvl_r || position_cmd < cblvl_r); // R13
   assign err_t = $signed({2'b00, tgt_r}) - $signed({2'b00, feedback_pos});
   assign err_p = $signed({2'b00, prof_r}) - $signed({2'b00, feedback_pos});
   assign abs_t = abs17(err_t);
   assign moving = abs_t > {1'b0, win_r};
   // speed command spans 0..100 % of the positive valve range
   assign vlim = ctrl_r.ext_speed ? {2'b00, speed_cmd[15:1]}
                                  : {2'b00, vlim_r[14:0]}; // R12

   // decel stroke added in the direction of travel, clamped to the stroke
   assign dec_sum   = {1'b0, feedback_pos} + {1'b0, decel_r};
   assign dec_dif   = $signed({2'b00, feedback_pos}) - $signed({2'b00, decel_r});
   assign decel_tgt = err_t[17] ? (dec_dif[17] ? 16'h0000 : dec_dif[15:0])
                                : (dec_sum[16] ? 16'hFFFF : dec_sum[15:0]);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   logic jog_any;
   assign jog_any = sw.jog_up || sw.jog_down;

   always_comb begin
      state_nxt = state_r;
      tgt_nxt   = tgt_r;
      if (!sw.enable) begin
         state_nxt = ST_OFF;
      end else begin
         case (state_r)
            ST_OFF: begin
               state_nxt = ST_HOLD;
               tgt_nxt   = feedback_pos; // R1
            end
            ST_HOLD: begin
               if (sw.start) begin
                  state_nxt = ST_RUN;
                  tgt_nxt   = position_cmd; // R8
               end else if (jog_any) begin
                  state_nxt = ST_JOG; // R6
               end
            end
            ST_JOG: begin
               // target trails the axis so releasing jog into hold never jumps
               tgt_nxt = feedback_pos; // R7
               if (sw.start) begin
                  state_nxt = ST_RUN;
                  tgt_nxt   = position_cmd;
               end else if (!jog_any) begin
                  state_nxt = ST_HOLD;
               end
            end
            ST_RUN: begin
               if (sw.start) begin
                  tgt_nxt = position_cmd; // R8
               end else begin
                  state_nxt = ST_HOLD;
                  if (moving)
                     tgt_nxt = decel_tgt; // R9
               end
            end
            default: state_nxt = ST_OFF;
         endcase
      end
   end

   // in run with nc_mode the profile ramps toward the target by the speed limit per sample, otherwise it takes the target
   assign rp     = $signed({2'b00, tgt_nxt}) - $signed({2'b00, prof_r});
   assign abs_rp = abs17(rp);
   assign step   = (abs_rp <= vlim) ? rp
                 : (rp[17] ? -$signed({1'b0, vlim}) : $signed({1'b0, vlim}));
   assign prof_nxt = (state_nxt == ST_RUN && ctrl_r.nc_mode)
                   ? prof_r + step[15:0] : tgt_nxt; // R11

   // ****************************************************************
   // control law
   // ****************************************************************
   logic signed [27:0] prod, scaled, lim, raw;
   logic signed [27:0] filt_r, filt_nxt, dz, pol;
   logic signed [27:0] vls, trs, mag_f;
   logic [15:0]        valve_nxt;

   // stroke dependent decel: saturating gain brakes over vlim/gain
   assign err_l  = ctrl_r.nc_mode ? err_p : err_t; // R11
   assign prod   = 28'(err_l) * $signed({20'h00000, gain_r});
   assign scaled = prod >>> GAIN_SHIFT;
   assign vls    = $signed({11'h000, vlim});
   assign lim    = (scaled > vls) ? vls : ((scaled < -vls) ? -vls : scaled); // R12
   assign raw    = (state_r == ST_JOG)
                 ? (sw.jog_up ? $signed({12'h000, jog_r})
                    : (sw.jog_down ? -$signed({12'h000, jog_r}) : 28'sd0))
                 : lim; // R6
   assign filt_nxt = filt_r + ((raw - filt_r) >>> filt_sh_r); // R14
   // slope two below the trigger, slope one above: no step at zero
   assign trs   = $signed({12'h000, trig_r});
   assign mag_f = filt_r[27] ? -filt_r : filt_r;
   assign dz    = filt_r + (filt_r[27] ? -((mag_f < trs) ? mag_f : trs)
                                       : ((mag_f < trs) ? mag_f : trs)); // R15
   assign pol   = ctrl_r.polarity_inv ? -dz : dz; // R10
   assign valve_nxt = (state_r == ST_OFF || fault)
                    ? (ctrl_r.emerg_disable ? 16'h0000 : emerg_r) // R16
                    : sat16(pol);

   // ****************************************************************
   // sample-boundary state
   // ****************************************************************
   logic [15:0]        valve_r;
   logic               ready_r, inpos_r, inpos_nxt, irq_r;
   logic signed [17:0] err_new;
   logic               moving_new;
   // window judged against the target taken at this tick, so a fresh
   // command far from the axis never flashes in-position for one sample
   assign err_new    = $signed({2'b00, tgt_nxt}) - $signed({2'b00, feedback_pos});
   assign moving_new = abs17(err_new) > {1'b0, win_r};
   assign inpos_nxt  = (state_nxt == ST_RUN) && !moving_new; // R4 R5
   assign events[IRQ_FAULT_BIT]  = fault && !fault_q_r;
   assign events[IRQ_INPOS_BIT]  = tick && inpos_nxt && !inpos_r;
   assign events[IRQ_ENLOSS_BIT] = tick && state_r != ST_OFF && !sw.enable;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_r   <= ST_OFF;
         tgt_r     <= 16'h0000;
         prof_r    <= 16'h0000;
         filt_r    <= 28'sd0;
         valve_r   <= 16'h0000;
         ready_r   <= 1'b0;
         inpos_r   <= 1'b0;
      end else if (tick) begin
         state_r   <= state_nxt; // R17
         tgt_r     <= tgt_nxt;
         prof_r    <= prof_nxt;
         filt_r    <= (state_r == ST_OFF) ? 28'sd0 : filt_nxt;
         valve_r   <= valve_nxt;
         ready_r   <= sw.enable && !fault; // R2 R3
         inpos_r   <= inpos_nxt;
      end
   end

   // interrupt status and level output
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         istat_r   <= '0;
         fault_q_r <= 1'b0;
         irq_r     <= 1'b0;
      end else begin
         istat_r   <= istat_nxt;
         fault_q_r <= fault;
         irq_r     <= |(istat_r & imask_r);
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   logic [DATA_W-1:0] rd_mux, rd_r;
   assign rd_mux =
      (addr == REG_CTRL)   ? {26'h0, ctrl_r}     :
      (addr == REG_WIN)    ? {16'h0, win_r}      :
      (addr == REG_JOG)    ? {16'h0, jog_r}      :
      (addr == REG_DECEL)  ? {16'h0, decel_r}    :
      (addr == REG_VLIM)   ? {16'h0, vlim_r}     :
      (addr == REG_EMERG)  ? {16'h0, emerg_r}    :
      (addr == REG_GAIN)   ? {24'h0, gain_r}     :
      (addr == REG_TRIG)   ? {16'h0, trig_r}     :
      (addr == REG_FILT)   ? {28'h0, filt_sh_r}  :
      (addr == REG_CBLVL)  ? {16'h0, cblvl_r}    :
      (addr == REG_STATUS) ? {27'h0, state_r, fault, inpos_r, ready_r} :
      (addr == REG_ISTAT)  ? {29'h0, istat_r}    :
      (addr == REG_IMASK)  ? {29'h0, imask_r}    :
      (addr == REG_MEAS)   ? {16'h0, feedback_pos} :
      (addr == REG_TARGET) ? {16'h0, tgt_r}      : 32'h0000_0000;

   // data only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         rd_r <= 32'h0000_0000;
      else
         rd_r <= rd_en ? rd_mux : 32'h0000_0000;
   end

   assign rd_data            = rd_r;
   assign valve_out          = valve_r;
   assign valve_current_mode = ctrl_r.current_mode; // R10
   assign ready_out          = ready_r;
   assign inpos_out          = inpos_r;
   assign irq                = irq_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_enable_load: assert property (tick && state_r == ST_OFF && sw.enable // R1
      |=> state_r == ST_HOLD && tgt_r == $past(feedback_pos))
      else $error("enable did not load measured position");
   a_ready_health: assert property (tick // R2
      |=> ready_r == $past(sw.enable && !fault))
      else $error("ready not tied to enable and health");
   a_ready_fault: assert property (tick && fault |=> !ready_r) // R3
      else $error("ready high with fault");
   a_inpos_window: assert property (tick && moving_new |=> !inpos_r) // R4
      else $error("in-position high outside window");
   a_inpos_start: assert property (inpos_r |-> state_r == ST_RUN) // R5
      else $error("in-position high without start");
   a_jog_drive: assert property (state_r == ST_JOG && sw.jog_up // R6
      |-> raw == $signed({12'h000, jog_r}))
      else $error("jog command not at jog velocity");
   a_jog_release: assert property (tick && state_r == ST_JOG && sw.enable // R7
      && !sw.start && !jog_any |=> state_r == ST_HOLD
      && tgt_r == $past(feedback_pos))
      else $error("jog release did not hold position");
   a_run_track: assert property (tick && state_r == ST_RUN && sw.enable // R8
      && sw.start |=> tgt_r == $past(position_cmd))
      else $error("run target not taken from command");
   a_stop_decel: assert property (tick && state_r == ST_RUN && sw.enable // R9
      && !sw.start && moving |=> tgt_r == $past(decel_tgt))
      else $error("stop did not add decel stroke");
   a_emerg_out: assert property (tick && (fault || state_r == ST_OFF) // R16
      && !ctrl_r.emerg_disable |=> valve_r == $past(emerg_r))
      else $error("emergency value not applied");
   a_tick_period: assert property (tick |=> !tick) // R17
      else $error("sample tick too frequent");

endmodule : stroke_position_sequencer

// file: plant_model.sv
// far-side model: position sensor holding a settable feedback value
`timescale 1ns/1ps
module plant_model
   import pos_seq_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             set_en,
   input  wire logic [POS_W-1:0] set_val,
   input  wire logic [POS_W-1:0] valve_out,
   output logic [POS_W-1:0]      feedback_pos
);
   // ****************************************************************
   // sensor
   // ****************************************************************
   // the sensor reads where the bench placed the axis; no motion model so
   // that every expected target stays exact
   always_ff @(posedge sys_clk) begin
      if (set_en) begin
         feedback_pos <= set_val;
      end
   end
endmodule : plant_model

// file: stroke_position_sequencer_test.sv
// self-checking bench of the stroke position sequencer
`timescale 1ns/1ps
module stroke_position_sequencer_test;
   import pos_seq_pkg::*;
   localparam int SC = 16;
   logic              sys_clk = 0;
   logic              resetn = 0;
   logic              enable_in = 0, start_in = 0, jog_up_in = 0, jog_down_in = 0;
   logic [POS_W-1:0]  position_cmd = 16'h2000, speed_cmd = 16'h0000;
   logic [POS_W-1:0]  feedback_pos, valve_out, fb_val = 16'h1000;
   logic              fb_set = 1, wr_en = 0, rd_en = 0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wr_data = 32'h0, rd_data;
   logic              valve_current_mode, ready_out, inpos_out, irq;
   int                n_fail = 0, samples_checked = 0, cyc = 0;
   logic [7:0]        ra [11] = '{REG_CTRL, REG_WIN, REG_JOG, REG_DECEL, REG_VLIM, REG_EMERG,
                                  REG_GAIN, REG_TRIG, REG_FILT, REG_CBLVL, 8'h3C};
   logic [31:0]       rv [11] = '{32'h0, 32'h40, 32'h1000, 32'h100, 32'h7FFF, 32'h0,
                                  32'h10, 32'h0, 32'h2, 32'h0CCC, 32'h0};

   stroke_position_sequencer #(.SAMPLE_CYCLES(SC)) stroke_position_sequencer_i (
      .sys_clk(sys_clk), .resetn(resetn), .enable_in(enable_in), .start_in(start_in),
      .jog_up_in(jog_up_in), .jog_down_in(jog_down_in), .position_cmd(position_cmd),
      .speed_cmd(speed_cmd), .feedback_pos(feedback_pos), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .valve_out(valve_out),
      .valve_current_mode(valve_current_mode), .ready_out(ready_out),
      .inpos_out(inpos_out), .irq(irq));
   plant_model plant_model_i (.sys_clk(sys_clk), .set_en(fb_set), .set_val(fb_val),
      .valve_out(valve_out), .feedback_pos(feedback_pos));

   // ****************************************************************
   // clock, timeout and tasks
   // ****************************************************************
   initial forever #2.5 sys_clk = ~sys_clk;
   // ceiling well above the roughly 740 cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk) begin wr_en <= 1; addr <= a; wr_data <= d; end
      @(posedge sys_clk) wr_en <= 0;
   endtask : wr
   task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
      @(posedge sys_clk) begin rd_en <= 1; addr <= a; end
      @(posedge sys_clk) rd_en <= 0;
      #1 chk(nm, e, rd_data);
   endtask : rd
   task automatic fb(logic [15:0] v);
      @(posedge sys_clk) fb_val <= v;
   endtask : fb
   task automatic ticks(int n);
      repeat (n * SC) @(posedge sys_clk);
      #1;
   endtask : ticks

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge sys_clk);
      resetn <= 1;
      for (int i = 0; i < 11; i++) rd("reset value", ra[i], rv[i]);
      chk("ready before enable", 0, ready_out);
      @(posedge sys_clk) enable_in <= 1;
      ticks(3);
      rd("status hold", REG_STATUS, 32'h09);
      rd("target at enable", REG_TARGET, 32'h1000);
      chk("ready", 1, ready_out);
      chk("inpos start off", 0, inpos_out);
      // jog, then invert polarity mid-jog
      @(posedge sys_clk) jog_up_in <= 1;
      ticks(4);
      rd("status jog", REG_STATUS, 32'h11);
      chk("jog drives up", 1, $signed(valve_out) > 0);
      wr(REG_CTRL, 32'h03);
      ticks(2);
      chk("inverted jog", 1, $signed(valve_out) < 0);
      chk("current form", 1, valve_current_mode);
      wr(REG_CTRL, 32'h00);
      fb(16'h2000);
      ticks(1);
      @(posedge sys_clk) jog_up_in <= 0;
      ticks(3);
      rd("target after jog", REG_TARGET, 32'h2000);
      rd("status after jog", REG_STATUS, 32'h09);
      // start takes over the command, window edges
      @(posedge sys_clk) begin position_cmd <= 16'h3000; start_in <= 1; end
      ticks(3);
      rd("target run", REG_TARGET, 32'h3000);
      chk("inpos far", 0, inpos_out);
      fb(16'h3040);
      ticks(2);
      chk("inpos at window", 1, inpos_out);
      fb(16'h3041);
      ticks(2);
      chk("inpos beyond window", 0, inpos_out);
      fb(16'h1000);
      ticks(2);
      @(posedge sys_clk) start_in <= 0;
      ticks(3);
      rd("target decel", REG_TARGET, 32'h1100);
      chk("inpos after stop", 0, inpos_out);
      // cable break on feedback, emergency value and interrupt
      wr(REG_ISTAT, 32'h7);
      wr(REG_EMERG, 32'h1234);
      wr(REG_IMASK, 32'h1);
      wr(REG_CTRL, 32'h20);
      fb(16'h0100);
      ticks(2);
      chk("ready on break", 0, ready_out);
      chk("emergency valve", 32'h1234, valve_out);
      rd("fault event", REG_ISTAT, 32'h1);
      chk("irq", 1, irq);
      wr(REG_ISTAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq cleared", 0, irq);
      wr(REG_CTRL, 32'h30);
      ticks(2);
      chk("emergency disabled", 0, valve_out);
      // cable break on the command input
      fb(16'h2000);
      @(posedge sys_clk) position_cmd <= 16'h0100;
      ticks(2);
      chk("ready cmd break", 0, ready_out);
      @(posedge sys_clk) position_cmd <= 16'h2000;
      ticks(2);
      chk("ready restored", 1, ready_out);
      // lag filter passes straight through, so limit and deadband slope show exactly
      wr(REG_FILT, 32'h0);
      wr(REG_VLIM, 32'h0800);
      wr(REG_TRIG, 32'h0100);
      ticks(2);
      chk("internal speed limit", 32'hF700, valve_out);
      @(posedge sys_clk) speed_cmd <= 16'h0400;
      wr(REG_CTRL, 32'h38);
      ticks(2);
      chk("external speed limit", 32'hFD00, valve_out);
      wr(REG_CTRL, 32'h00);
      wr(REG_ISTAT, 32'h7);
      @(posedge sys_clk) enable_in <= 0;
      ticks(3);
      chk("ready enable lost", 0, ready_out);
      rd("enable lost event", REG_ISTAT, 32'h4);
      rd("status off", REG_STATUS, 32'h00);
      end_sim();
   end
endmodule : stroke_position_sequencer_test
